//--- rtl/ftcr_pkg.sv
// Shared constants and types for the fast timer compare register block
package ftcr_pkg;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned CMP_W = 11;
  localparam int unsigned STG_W = 3;
  localparam int unsigned OE_W = 6;
  localparam int unsigned SEL_W = 4;
  // Register indices on the 8-bit register port
  localparam logic [3:0] IDX_CTRL_E = 4'h0;
  localparam logic [3:0] IDX_COUNTER = 4'h1;
  localparam logic [3:0] IDX_STAGING = 4'h2;
  localparam logic [3:0] IDX_CMP_A = 4'h3;
  localparam logic [3:0] IDX_CMP_B = 4'h4;
  localparam logic [3:0] IDX_PERIOD = 4'h5;
  localparam logic [3:0] IDX_CMP_D = 4'h6;
  localparam logic [3:0] IDX_MASK = 4'h7;
  localparam logic [3:0] IDX_FLAGS = 4'h8;
  // Field positions
  localparam int unsigned LOCK_BIT = 7;
  localparam int unsigned ENH_BIT = 6;
  localparam int unsigned D_BIT = 7;
  localparam int unsigned A_BIT = 6;
  localparam int unsigned B_BIT = 5;
  localparam int unsigned OV_BIT = 2;
  localparam int unsigned STG_EXTRA_BIT = 2;
  // Reset values and limits
  localparam logic [9:0] PERIOD_MIN = 10'h003;
  localparam logic [9:0] PERIOD_RST = 10'h3ff;
  localparam logic [9:0] CNT_BOTTOM = 10'h000;
  localparam logic [10:0] CMP_RST = 11'h000;
  // Counter write latency: 1.5 cycles in synchronous mode rounds up to 2
  localparam int unsigned SYNC_WR_HALF_CYCLES = 3;
  localparam logic [1:0] SYNC_WR_DLY = 2'((SYNC_WR_HALF_CYCLES + 1) / 2);
  localparam logic [1:0] ASYNC_WR_DLY = 2'h1;
  // Interrupt request vector order
  localparam int unsigned IRQ_A = 0;
  localparam int unsigned IRQ_B = 1;
  localparam int unsigned IRQ_D = 2;
  localparam int unsigned IRQ_OV = 3;
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } ftcr_dir_t;
endpackage

//--- rtl/ftcr_cmp_unit.sv
// One compare channel: update buffer, lock transfer, match event and flag
`timescale 1ns/1ps
`default_nettype none
module ftcr_cmp_unit
  import ftcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wr_stage,
  input wire logic [CMP_W-1:0] wr_value,
  input wire logic lock,
  input wire logic enhanced,
  input wire logic upd_ok,
  input wire logic [CNT_W-1:0] cnt,
  input wire logic counted,
  input wire logic flag_w1,
  input wire logic flag_ack,
  output logic [CMP_W-1:0] buf_val,
  output logic evt,
  output logic flag
);
  typedef struct packed {
    logic [CMP_W-1:0] stage_buf;
    logic [CMP_W-1:0] act;
    logic pend;
    logic late_hit;
    logic evt;
    logic flag;
    logic clr_pend;
  } ftcr_cu_state_t;
  ftcr_cu_state_t s_reg, s_next;
  logic hit;

  always_comb begin
    s_next = s_reg;
    // Only a counting step can hit, so a software write never matches
    hit = counted && (cnt == s_reg.act[CMP_W-1:1]);
    if (wr_stage) begin
      s_next.stage_buf = wr_value;
      s_next.pend = 1'b1;
    end
    if (s_reg.pend && !wr_stage && !lock && upd_ok) begin
      s_next.act = s_reg.stage_buf;
      s_next.pend = 1'b0;
    end
    // Extra LSB defers the event to the later edge
    s_next.late_hit = hit && enhanced && s_reg.act[0];
    s_next.evt = (hit && !(enhanced && s_reg.act[0])) || s_reg.late_hit;
    s_next.clr_pend = flag_w1;
    if (s_reg.clr_pend || flag_ack) begin
      s_next.flag = 1'b0;
    end
    // Set one cycle after the event and wins over a clear
    if (s_reg.evt) begin
      s_next.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign buf_val = s_reg.stage_buf;
  assign evt = s_reg.evt;
  assign flag = s_reg.flag;

  ////////////////////////////////////////////////////////////////////////////
  chk_lock_holds: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    lock |=> $stable(s_reg.act)) else $error("Active compare changed while locked");
  chk_flag_sets: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    s_reg.evt |=> s_reg.flag) else $error("Match event did not set flag");
  chk_flag_sticks: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    s_reg.flag && !s_reg.clr_pend && !flag_ack |=> s_reg.flag) else $error("Flag lost");
  chk_no_sw_match: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    !counted && !s_reg.late_hit |=> !s_reg.evt) else $error("Match without count step");
  chk_w1_clears: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    flag_w1 && !s_reg.evt ##1 !s_reg.evt |=> !s_reg.flag) else $error("Write-one clear failed");
  cov_late_edge: cover property (@(posedge clk_sys) disable iff (!nrst) s_reg.late_hit ##1 s_reg.evt);
endmodule
`default_nettype wire

//--- rtl/ftcr_top.sv
// Fast timer compare register block: counter, staging, compares, flags, pins
//
// Function
// - While locked, compare writes are buffered; transfer happens once unlocked.
// - Enhanced mode adds an LSB to A, B, D choosing the event edge.
// - In six-output mode override bits connect pins; clear shows port value.
// - Override bits pair: 0,1 channel A; 2,3 channel B; 4,5 channel D.
// - Counter is 10-bit up/down, readable and writable, usable as 8-bit.
// - Counter write lands after two cycles synchronous (1.5 rounded up), one cycle asynchronous.
// - Any counter write makes the counter count upward.
// - One shared staging register carries the high bits of 10-bit accesses.
// - Staging bit 2 is the extra top bit for 11-bit enhanced values.
// - Staging bits 7 to 3 always read zero.
// - Matches on A, B, D only when counting reaches the compare value.
// - A match sets its channel flag after a synchronisation delay.
// - Match with period register clears the counter, except in dual slope PWM where it turns the count down.
// - Period writes below three are stored as three.
// - Mask bits 7, 6, 5 enable D, A, B matches with global enable.
// - Mask bit 2 enables overflow interrupt; overflow sets overflow flag.
// - Flags D and A set on match; clear by vector or write-one.
// - Compare request only while global enable, mask bit and flag all set.
// - Overflow sets at TOP wrap in single slope, at BOTTOM in dual slope.
// - Flag B sets on match; clears by vector or delayed write-one.
`timescale 1ns/1ps
`default_nettype none
module ftcr_top
  import ftcr_pkg::*;
#(
  parameter int unsigned COUNT_W = CNT_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [SEL_W-1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cnt_tick,
  input wire logic pwm_mode,
  input wire logic dual_slope,
  input wire logic six_output_pwm_mode,
  input wire logic async_clock_mode,
  input wire logic cpu_irq_enable,
  input wire logic [3:0] irq_ack,
  input wire logic [OE_W-1:0] port_value,
  output logic [OE_W-1:0] waveform_pins,
  output logic [3:0] irq_req
);
  if (COUNT_W != CNT_W) begin : g_bad_width
    $error("ftcr_top supports only a 10-bit counter");
  end

  typedef struct packed {
    logic lock;
    logic enh;
    logic [OE_W-1:0] oe;
    logic [CNT_W-1:0] cnt;
    ftcr_dir_t dir;
    logic counted;
    logic [1:0] wr_wait;
    logic [CNT_W-1:0] wr_val;
    logic [STG_W-1:0] stg;
    logic [CNT_W-1:0] per_buf;
    logic [CNT_W-1:0] per;
    logic per_pend;
    logic [3:0] mask;
    logic ovf;
    logic ovf_clr;
    logic wrap;
    logic [2:0] wave;
    logic [OE_W-1:0] pins;
    logic [3:0] irq;
    logic [7:0] rdata;
  } ftcr_state_t;
  ftcr_state_t s_reg, s_next;

  logic wr_a, wr_b, wr_d;
  logic [CMP_W-1:0] cmp_wval;
  logic upd_ok;
  logic [2:0] w1;
  logic [CMP_W-1:0] buf_a, buf_b, buf_d;
  logic [2:0] evt, flg;
  logic [CMP_W-1:0] rd_cmp;
  logic [CNT_W-1:0] per_in;

  // Low-byte writes merge with the shared staging bits
  assign cmp_wval = s_reg.enh ? {s_reg.stg, reg_wdata} : {s_reg.stg[1:0], reg_wdata, 1'b0};
  assign wr_a = reg_wr && (reg_sel == IDX_CMP_A);
  assign wr_b = reg_wr && (reg_sel == IDX_CMP_B);
  assign wr_d = reg_wr && (reg_sel == IDX_CMP_D);
  // Normal mode updates at once; PWM modes wait for the wrap or bottom point
  assign upd_ok = !pwm_mode || s_reg.wrap;
  assign w1 = (reg_wr && (reg_sel == IDX_FLAGS)) ? {reg_wdata[D_BIT], reg_wdata[B_BIT], reg_wdata[A_BIT]} : 3'h0;
  assign per_in = {s_reg.stg[1:0], reg_wdata};

  ftcr_cmp_unit u_cmp_a (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wr_stage(wr_a), .wr_value(cmp_wval),
    .lock(s_reg.lock), .enhanced(s_reg.enh), .upd_ok(upd_ok), .cnt(s_reg.cnt), .counted(s_reg.counted),
    .flag_w1(w1[0]), .flag_ack(irq_ack[IRQ_A]), .buf_val(buf_a), .evt(evt[0]), .flag(flg[0]));
  ftcr_cmp_unit u_cmp_b (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wr_stage(wr_b), .wr_value(cmp_wval),
    .lock(s_reg.lock), .enhanced(s_reg.enh), .upd_ok(upd_ok), .cnt(s_reg.cnt), .counted(s_reg.counted),
    .flag_w1(w1[1]), .flag_ack(irq_ack[IRQ_B]), .buf_val(buf_b), .evt(evt[1]), .flag(flg[1]));
  ftcr_cmp_unit u_cmp_d (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wr_stage(wr_d), .wr_value(cmp_wval),
    .lock(s_reg.lock), .enhanced(s_reg.enh), .upd_ok(upd_ok), .cnt(s_reg.cnt), .counted(s_reg.counted),
    .flag_w1(w1[2]), .flag_ack(irq_ack[IRQ_D]), .buf_val(buf_d), .evt(evt[2]), .flag(flg[2]));

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.counted = 1'b0;
    s_next.wrap = 1'b0;
    rd_cmp = CMP_RST;
    // Register writes
    if (reg_wr) begin
      case (reg_sel)
        IDX_CTRL_E: begin
          s_next.lock = reg_wdata[LOCK_BIT];
          s_next.enh = reg_wdata[ENH_BIT];
          s_next.oe = reg_wdata[OE_W-1:0];
        end
        IDX_COUNTER: begin
          s_next.wr_val = {s_reg.stg[1:0], reg_wdata};
          s_next.wr_wait = async_clock_mode ? ASYNC_WR_DLY : SYNC_WR_DLY;
        end
        IDX_STAGING: s_next.stg = reg_wdata[STG_W-1:0];
        IDX_PERIOD: begin
          s_next.per_buf = (per_in < PERIOD_MIN) ? PERIOD_MIN : per_in;
          s_next.per_pend = 1'b1;
        end
        IDX_MASK: s_next.mask = {reg_wdata[OV_BIT], reg_wdata[D_BIT], reg_wdata[B_BIT], reg_wdata[A_BIT]};
        default: ;
      endcase
    end
    if (s_reg.per_pend && !(reg_wr && reg_sel == IDX_PERIOD) && !s_reg.lock && upd_ok) begin
      s_next.per = s_reg.per_buf;
      s_next.per_pend = 1'b0;
    end
    // Counter: a landing write beats the tick and forces the up direction
    if (s_reg.wr_wait != 2'h0 && !(reg_wr && reg_sel == IDX_COUNTER)) begin
      s_next.wr_wait = s_reg.wr_wait - 2'h1;
    end
    if (s_reg.wr_wait == 2'h1) begin
      s_next.cnt = s_reg.wr_val;
      s_next.dir = DIR_UP;
    end else if (cnt_tick) begin
      s_next.counted = 1'b1;
      if (!pwm_mode || !dual_slope) begin
        if (s_reg.cnt >= s_reg.per) begin
          s_next.cnt = CNT_BOTTOM;
          s_next.wrap = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 10'h001;
        end
      end else if (s_reg.dir == DIR_UP) begin
        if (s_reg.cnt >= s_reg.per) begin
          s_next.dir = DIR_DOWN;
          s_next.cnt = s_reg.cnt - 10'h001;
        end else begin
          s_next.cnt = s_reg.cnt + 10'h001;
        end
      end else begin
        s_next.cnt = s_reg.cnt - 10'h001;
        if (s_reg.cnt == 10'h001) begin
          s_next.wrap = 1'b1;
          s_next.dir = DIR_UP;
        end
      end
    end
    // Overflow flag: delayed write-one clear, hardware set wins
    s_next.ovf_clr = reg_wr && (reg_sel == IDX_FLAGS) && reg_wdata[OV_BIT];
    if (s_reg.ovf_clr || irq_ack[IRQ_OV]) begin
      s_next.ovf = 1'b0;
    end
    if (s_reg.wrap) begin
      s_next.ovf = 1'b1;
    end
    // Simple waveform per channel: set at wrap, cleared on the compare event
    for (int i = 0; i < 3; i++) begin
      if (evt[i]) begin
        s_next.wave[i] = 1'b0;
      end else if (s_reg.wrap) begin
        s_next.wave[i] = 1'b1;
      end
    end
    // Override enables take effect immediately on the next registered pin level
    for (int i = 0; i < OE_W; i++) begin
      if (six_output_pwm_mode && s_reg.oe[i]) begin
        s_next.pins[i] = s_reg.wave[i/2] ^ i[0];
      end else begin
        s_next.pins[i] = port_value[i];
      end
    end
    s_next.irq[IRQ_A] = cpu_irq_enable && s_reg.mask[0] && flg[0];
    s_next.irq[IRQ_B] = cpu_irq_enable && s_reg.mask[1] && flg[1];
    s_next.irq[IRQ_D] = cpu_irq_enable && s_reg.mask[2] && flg[2];
    s_next.irq[IRQ_OV] = cpu_irq_enable && s_reg.mask[3] && s_reg.ovf;
    // Reads; low-byte reads latch the high bits into staging
    if (reg_rd) begin
      s_next.rdata = 8'h00;
      case (reg_sel)
        IDX_CTRL_E: s_next.rdata = {s_reg.lock, s_reg.enh, s_reg.oe};
        IDX_COUNTER: begin
          s_next.rdata = s_reg.cnt[7:0];
          s_next.stg = {1'b0, s_reg.cnt[9:8]};
        end
        IDX_STAGING: s_next.rdata = {5'h00, s_reg.stg};
        IDX_PERIOD: begin
          s_next.rdata = s_reg.per_buf[7:0];
          s_next.stg = {1'b0, s_reg.per_buf[9:8]};
        end
        IDX_CMP_A, IDX_CMP_B, IDX_CMP_D: begin
          rd_cmp = (reg_sel == IDX_CMP_A) ? buf_a : ((reg_sel == IDX_CMP_B) ? buf_b : buf_d);
          s_next.rdata = s_reg.enh ? rd_cmp[7:0] : rd_cmp[8:1];
          s_next.stg = s_reg.enh ? rd_cmp[10:8] : {1'b0, rd_cmp[10:9]};
        end
        IDX_MASK: begin
          s_next.rdata[D_BIT] = s_reg.mask[2];
          s_next.rdata[A_BIT] = s_reg.mask[0];
          s_next.rdata[B_BIT] = s_reg.mask[1];
          s_next.rdata[OV_BIT] = s_reg.mask[3];
        end
        IDX_FLAGS: begin
          s_next.rdata[D_BIT] = flg[2];
          s_next.rdata[A_BIT] = flg[0];
          s_next.rdata[B_BIT] = flg[1];
          s_next.rdata[OV_BIT] = s_reg.ovf;
        end
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.per <= PERIOD_RST;
      s_reg.per_buf <= PERIOD_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign waveform_pins = s_reg.pins;
  assign irq_req = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  chk_period_floor: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    reg_wr && reg_sel == IDX_PERIOD && per_in < PERIOD_MIN |=> s_reg.per_buf == PERIOD_MIN)
    else $error("Period below minimum stored");
  chk_cnt_async_lat: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    reg_wr && reg_sel == IDX_COUNTER && async_clock_mode ##1 !(reg_wr && reg_sel == IDX_COUNTER)
    |=> s_reg.cnt == $past(s_reg.wr_val) && s_reg.dir == DIR_UP)
    else $error("Counter write landed late or wrong");
  chk_up_after_wr: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    s_reg.wr_wait == 2'h1 |=> s_reg.dir == DIR_UP) else $error("Counter not counting up after write");
  chk_stage_resv: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    reg_rd && reg_sel == IDX_STAGING |=> reg_rdata[7:3] == 5'h00) else $error("Reserved staging bits set");
  chk_ovf_irq: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    ##1 irq_req[IRQ_OV] == $past(cpu_irq_enable && s_reg.mask[3] && s_reg.ovf))
    else $error("Overflow request not gated");
  chk_pin_port: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    !(six_output_pwm_mode && s_reg.oe[0]) |=> waveform_pins[0] == $past(port_value[0]))
    else $error("Pin not showing port value");
  chk_period_wrap: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    cnt_tick && !pwm_mode && s_reg.wr_wait != 2'h1 && s_reg.cnt >= s_reg.per
    |=> s_reg.cnt == CNT_BOTTOM ##1 s_reg.ovf) else $error("Period match did not clear counter");
  chk_cnt_sync_lat: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    reg_wr && reg_sel == IDX_COUNTER && !async_clock_mode ##1 !(reg_wr && reg_sel == IDX_COUNTER)
    ##1 !(reg_wr && reg_sel == IDX_COUNTER) |=> s_reg.cnt == $past(s_reg.wr_val) && s_reg.dir == DIR_UP)
    else $error("Synchronous counter write landed late or wrong");
  chk_dual_bottom: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    cnt_tick && pwm_mode && dual_slope && s_reg.wr_wait != 2'h1
    && s_reg.dir == DIR_DOWN && s_reg.cnt == 10'h001
    |=> s_reg.cnt == CNT_BOTTOM ##1 s_reg.ovf) else $error("Bottom did not flag overflow");
  // A stored period below the floor would let the counter run past its wrap point
  chk_period_min: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    s_reg.per >= PERIOD_MIN && s_reg.per_buf >= PERIOD_MIN) else $error("Period below minimum");
  chk_lock_period: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    s_reg.lock |=> $stable(s_reg.per)) else $error("Active period changed while locked");
  // Overflow flag bookkeeping
  chk_ovf_sticks: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    s_reg.ovf && !s_reg.ovf_clr && !irq_ack[IRQ_OV] |=> s_reg.ovf) else $error("Overflow flag lost");
  chk_ovf_w1c: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    s_reg.ovf_clr && !s_reg.wrap |=> !s_reg.ovf) else $error("Overflow write-one clear failed");
  chk_irq_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    ##1 irq_req[IRQ_A] == $past(cpu_irq_enable && s_reg.mask[0] && flg[0]))
    else $error("Match A request not gated");
  chk_pin_pair: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
    six_output_pwm_mode && s_reg.oe[1] |=> waveform_pins[1] == !$past(s_reg.wave[0]))
    else $error("Complement pin not inverted");
  // Enable low must freeze every register of the block
  chk_ce_freeze: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ce |=> $stable(s_reg)) else $error("State moved while clock enable was low");
  cov_wrap: cover property (@(posedge clk_sys) disable iff (!nrst) s_reg.wrap ##1 s_reg.ovf);
  cov_lock_release: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(s_reg.lock));
  cov_irq_a: cover property (@(posedge clk_sys) disable iff (!nrst) irq_req[IRQ_A]);
  cov_dual_turn: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(s_reg.dir == DIR_DOWN));
endmodule
`default_nettype wire

//--- testbench/tb_fast_timer_compare_regs.sv
// Self-checking register-level testbench for the fast timer compare block
`timescale 1ns/1ps
`default_nettype none
module tb_fast_timer_compare_regs
  import ftcr_pkg::*;
;
  logic clk_sys;
  logic nrst;
  logic ce;
  logic [SEL_W-1:0] reg_sel;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic cnt_tick;
  logic pwm_mode;
  logic dual_slope;
  logic six_output_pwm_mode;
  logic async_clock_mode;
  logic cpu_irq_enable;
  logic [3:0] irq_ack;
  logic [OE_W-1:0] port_value;
  logic [OE_W-1:0] waveform_pins;
  logic [3:0] irq_req;
  logic [7:0] d;
  int bad_count;
  int checks;

  ftcr_top DUT (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cnt_tick(cnt_tick),
    .pwm_mode(pwm_mode), .dual_slope(dual_slope), .six_output_pwm_mode(six_output_pwm_mode),
    .async_clock_mode(async_clock_mode), .cpu_irq_enable(cpu_irq_enable), .irq_ack(irq_ack),
    .port_value(port_value), .waveform_pins(waveform_pins), .irq_req(irq_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Every driver changes inputs 2 ns after the rising edge
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic wr(input logic [3:0] sel, input logic [7:0] data);
    @(posedge clk_sys);
    #2;
    reg_sel = sel;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #2;
    reg_wr = 1'b0;
  endtask

  // Read data is registered at the taking edge and holds, so sample one edge later
  task automatic rd(input logic [3:0] sel, output logic [7:0] data);
    @(posedge clk_sys);
    #2;
    reg_sel = sel;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #2;
    reg_rd = 1'b0;
    @(posedge clk_sys);
    #2;
    data = reg_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Whole sequence needs about 440 cycles; allow 20000, some forty-five times that
  initial begin
    #(40 * 20000);
    bad_count++;
    print_verdict();
  end

  initial begin
    bad_count = 0;
    checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    reg_sel = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    cnt_tick = 1'b0;
    pwm_mode = 1'b0;
    dual_slope = 1'b0;
    six_output_pwm_mode = 1'b0;
    async_clock_mode = 1'b0;
    cpu_irq_enable = 1'b0;
    irq_ack = 4'h0;
    port_value = 6'h00;
    repeat (16) @(posedge clk_sys);
    #2;
    nrst = 1'b1;
    // Reset values and the unmapped index
    rd(IDX_CTRL_E, d); check("control_e", d, 8'h00);
    rd(IDX_PERIOD, d); check("period_low", d, 8'hff);
    rd(IDX_STAGING, d); check("period_high", d, 8'h03);
    rd(IDX_MASK, d); check("mask", d, 8'h00);
    rd(IDX_FLAGS, d); check("flags", d, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, d); check("unmapped", d, 8'h00);
    // Staging register keeps only three bits
    wr(IDX_STAGING, 8'hff);
    rd(IDX_STAGING, d); check("staging", d, 8'h07);
    wr(IDX_STAGING, 8'h00);
    wr(IDX_PERIOD, 8'h01);
    rd(IDX_PERIOD, d); check("period_floor", d, 8'h03);
    wr(IDX_PERIOD, 8'h0a);
    // Ten-bit counter through the shared staging byte
    wr(IDX_STAGING, 8'h02);
    async_clock_mode = 1'b1;
    wr(IDX_COUNTER, 8'h34);
    async_clock_mode = 1'b0;
    rd(IDX_COUNTER, d); check("counter_low", d, 8'h34);
    rd(IDX_STAGING, d); check("counter_high", d, 8'h02);
    wr(IDX_STAGING, 8'h00);
    // Software making counter equal to compare must not flag a match
    wr(IDX_CMP_A, 8'h07);
    wr(IDX_COUNTER, 8'h07);
    idle(6);
    rd(IDX_FLAGS, d); check("no_soft_match", d, 8'h00);
    // Counting sets flags; a clear mask keeps requests low
    cpu_irq_enable = 1'b1;
    cnt_tick = 1'b1;
    idle(30);
    check("irq_masked", {4'h0, irq_req}, 8'h00);
    cnt_tick = 1'b0;
    rd(IDX_FLAGS, d); check("flags_a_ov", d & 8'h44, 8'h44);
    wr(IDX_FLAGS, 8'h00);
    rd(IDX_FLAGS, d); check("zero_write", d & 8'h44, 8'h44);
    wr(IDX_MASK, 8'h44);
    idle(3);
    check("irq_a_ov", {4'h0, irq_req}, 8'h09);
    irq_ack = 4'h1;
    idle(1);
    irq_ack = 4'h0;
    idle(3);
    check("irq_after_ack", {4'h0, irq_req}, 8'h08);
    rd(IDX_FLAGS, d); check("flags_after_ack", d & 8'h44, 8'h04);
    wr(IDX_FLAGS, 8'h04);
    idle(2);
    rd(IDX_FLAGS, d); check("ov_w1c", d & 8'h04, 8'h00);
    cpu_irq_enable = 1'b0;
    cnt_tick = 1'b1;
    idle(30);
    check("irq_global_off", {4'h0, irq_req}, 8'h00);
    cpu_irq_enable = 1'b1;
    idle(3);
    check("irq_global_on", {4'h0, irq_req}, 8'h09);
    // Lock holds the new D value back while B keeps working
    cnt_tick = 1'b0;
    wr(IDX_STAGING, 8'h03);
    wr(IDX_CMP_D, 8'hfe);
    wr(IDX_STAGING, 8'h00);
    wr(IDX_CMP_B, 8'h05);
    wr(IDX_CTRL_E, 8'h80);
    wr(IDX_CMP_D, 8'h04);
    wr(IDX_FLAGS, 8'hff);
    cnt_tick = 1'b1;
    idle(40);
    rd(IDX_FLAGS, d); check("flags_locked", d, 8'h64);
    wr(IDX_CTRL_E, 8'h00);
    wr(IDX_FLAGS, 8'hff);
    idle(40);
    rd(IDX_FLAGS, d); check("flags_unlocked", d, 8'he4);
    // Pin override enables
    cnt_tick = 1'b0;
    port_value = 6'h2a;
    wr(IDX_CTRL_E, 8'h3f);
    idle(2);
    check("pins_port", {2'h0, waveform_pins}, 8'h2a);
    six_output_pwm_mode = 1'b1;
    idle(2);
    d = {5'h0, waveform_pins[1] ^ waveform_pins[0], waveform_pins[3] ^ waveform_pins[2],
         waveform_pins[5] ^ waveform_pins[4]};
    check("pin_pairs", d, 8'h07);
    wr(IDX_CTRL_E, 8'h03);
    idle(2);
    check("pins_b_d_port", {4'h0, waveform_pins[5:2]}, 8'h0a);
    check("pins_a_pair", {7'h0, waveform_pins[1] ^ waveform_pins[0]}, 8'h01);
    wr(IDX_CTRL_E, 8'h00);
    six_output_pwm_mode = 1'b0;
    // Dual slope: a counter write while counting down restarts upward
    pwm_mode = 1'b1;
    dual_slope = 1'b1;
    wr(IDX_COUNTER, 8'h00);
    cnt_tick = 1'b1;
    idle(15);
    cnt_tick = 1'b0;
    wr(IDX_COUNTER, 8'h03);
    idle(3);
    cnt_tick = 1'b1;
    idle(1);
    cnt_tick = 1'b0;
    idle(3);
    rd(IDX_COUNTER, d); check("count_up", d, 8'h04);
    // Enable low freezes the counter although ticks arrive
    ce = 1'b0;
    cnt_tick = 1'b1;
    idle(5);
    ce = 1'b1;
    cnt_tick = 1'b0;
    rd(IDX_COUNTER, d); check("ce_freeze", d, 8'h04);
    wr(IDX_FLAGS, 8'h04);
    cnt_tick = 1'b1;
    idle(25);
    cnt_tick = 1'b0;
    rd(IDX_FLAGS, d); check("ov_bottom", d & 8'h04, 8'h04);
    // Enhanced mode: staging bit 2 joins the value; an odd A of 0x15 matches at 10 only here
    wr(IDX_CTRL_E, 8'h40);
    wr(IDX_STAGING, 8'h04);
    wr(IDX_CMP_B, 8'h07);
    rd(IDX_CMP_B, d); check("enh_low", d, 8'h07);
    rd(IDX_STAGING, d); check("enh_high", d, 8'h04);
    wr(IDX_STAGING, 8'h00);
    wr(IDX_CMP_A, 8'h15);
    cnt_tick = 1'b1;
    idle(45);
    wr(IDX_FLAGS, 8'h40);
    idle(25);
    cnt_tick = 1'b0;
    rd(IDX_FLAGS, d); check("enh_match_a", d & 8'h40, 8'h40);
    print_verdict();
  end
endmodule
`default_nettype wire
